/* verilog/phy_np_role_regs.sv */
// Management register bank: next-page words, role and duplex control, test and wiring mode.
// Assumes an APB master on REF_CLK and a negotiation engine that consumes the applied outputs.
//
// The APB register port is this design's own decision.
`include "phy_regs_params.svh"
`default_nettype none

module phy_np_role_regs (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Negotiation engine
  input wire logic AN_COMPLETE,
  input wire logic PAGE_RX_STB,
  input wire logic [15:0] PAGE_RX_WORD,
  input wire logic PAGE_TX_DONE,
  output logic [15:0] TX_PAGE_WORD,
  output logic RESTART_AN,
  output logic SOFT_RESET,
  // Applied role and advertisement
  output logic MANUAL_ROLE_EN,
  output logic ROLE_MASTER_WANTED,
  output logic ADV_FULL_DUPLEX,
  output logic ADV_HALF_DUPLEX,
  // Line test and wiring
  output var phy_regs_pkg::test_mode_t TX_TEST_MODE,
  output var phy_regs_pkg::xover_t CROSSED_WIRING_MODE
);
  import phy_regs_pkg::*;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'h0};
  endfunction

  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic mapped;
  logic [15:0] rd_word;
  logic [31:0] prdata_d;
  logic pslverr_d;
  logic page_clear;
  logic [15:0] rx_word;
  logic page_flag;

  // Transmit page state
  logic tx_next_q, tx_next_d;
  logic tx_mp_q, tx_mp_d;
  logic tx_ack2_q, tx_ack2_d;
  logic tx_tog_q, tx_tog_d;
  logic [10:0] tx_code_q, tx_code_d;

  // Role, test and wiring state
  test_mode_t test_q, test_d;
  logic man_en_q, man_en_d;
  logic man_val_q, man_val_d;
  logic port_q, port_d;
  logic fd_q, fd_d;
  logic hd_q, hd_d;
  xover_t xo_wr_q, xo_wr_d;
  xover_t xo_act_q, xo_act_d;
  test_mode_t test_out_d;
  logic role_out_d;
  logic man_en_out_d;
  logic fd_out_d;
  logic hd_out_d;

  // Control pulses
  logic swrst_q, swrst_d;
  logic restart_q, restart_d;

  assign setup = PSEL & ~PENABLE;
  assign acc_wr = PSEL & PENABLE & PWRITE;
  assign acc_rd = PSEL & PENABLE & ~PWRITE;
  // Zero wait states keep the slave simple; every access ends after one access cycle
  assign PREADY = 1'h1;

  always_comb begin
    rd_word = 16'h0000;
    mapped = (PADDR[1:0] == 2'h0);
    case (PADDR[7:2])
      `IDX_CTRL: rd_word = 16'h0000;
      // Flag only shows once negotiation is complete
      `IDX_STAT: rd_word[`STAT_PAGE_BIT] = page_flag & AN_COMPLETE;
      `IDX_TXP: rd_word = {tx_next_q, 1'h0, tx_mp_q, tx_ack2_q, tx_tog_q, tx_code_q};
      `IDX_RXP: rd_word = rx_word;
      `IDX_ROLE: rd_word = {test_q, man_en_q, man_val_q, port_q, fd_q, hd_q, 8'h00};
      `IDX_XOVER: rd_word[`XO_MSB:`XO_LSB] = xo_wr_q;
      default: mapped = 1'h0;
    endcase
  end

  always_comb begin
    prdata_d = PRDATA;
    pslverr_d = PSLVERR;
    if (setup) begin
      prdata_d = PWRITE ? 32'h0000_0000 : {16'h0000, rd_word};
      pslverr_d = ~mapped;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'h0;
    end else begin
      PRDATA <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  // Only a flag that the finished read actually reported is cleared
  assign page_clear = acc_rd & wr_hit(PADDR, `IDX_STAT) & PRDATA[`STAT_PAGE_BIT];

  partner_page_capture u_capture (
    .clk(REF_CLK),
    .rst(RST),
    .sw_rst(swrst_q),
    .page_stb(PAGE_RX_STB),
    .page_word(PAGE_RX_WORD),
    .clear_req(page_clear),
    .rx_word_q(rx_word),
    .page_flag_q(page_flag)
  );

  always_comb begin
    swrst_d = acc_wr & wr_hit(PADDR, `IDX_CTRL) & PWDATA[`CTRL_SWRST_BIT];
    restart_d = acc_wr & wr_hit(PADDR, `IDX_CTRL) & PWDATA[`CTRL_RESTART_BIT];
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      swrst_q <= 1'h0;
      restart_q <= 1'h0;
    end else begin
      swrst_q <= swrst_d;
      restart_q <= restart_d;
    end
  end

  assign SOFT_RESET = swrst_q;
  assign RESTART_AN = restart_q;

  always_comb begin
    tx_next_d = tx_next_q;
    tx_mp_d = tx_mp_q;
    tx_ack2_d = tx_ack2_q;
    tx_tog_d = tx_tog_q;
    tx_code_d = tx_code_q;
    if (swrst_q) begin
      tx_next_d = `TXP_NEXT_RST;
      tx_mp_d = `TXP_MP_RST;
      tx_ack2_d = `TXP_ACK2_RST;
      tx_tog_d = `TXP_TOG_RST;
      tx_code_d = `TXP_CODE_RST;
    end else begin
      // Toggle is hardware owned; each sent page flips it for the next one
      if (PAGE_TX_DONE) begin
        tx_tog_d = ~tx_tog_q;
      end
      if (acc_wr && wr_hit(PADDR, `IDX_TXP)) begin
        tx_next_d = PWDATA[`PG_NEXT_BIT];
        tx_mp_d = PWDATA[`PG_MP_BIT];
        tx_ack2_d = PWDATA[`PG_ACK2_BIT];
        tx_code_d = PWDATA[`PG_CODE_MSB:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_next_q <= `TXP_NEXT_RST;
      tx_mp_q <= `TXP_MP_RST;
      tx_ack2_q <= `TXP_ACK2_RST;
      tx_tog_q <= `TXP_TOG_RST;
      tx_code_q <= `TXP_CODE_RST;
      TX_PAGE_WORD <= {`TXP_NEXT_RST, 1'h0, `TXP_MP_RST, `TXP_ACK2_RST, `TXP_TOG_RST,
                       `TXP_CODE_RST};
    end else begin
      tx_next_q <= tx_next_d;
      tx_mp_q <= tx_mp_d;
      tx_ack2_q <= tx_ack2_d;
      tx_tog_q <= tx_tog_d;
      tx_code_q <= tx_code_d;
      TX_PAGE_WORD <= {tx_next_d, 1'h0, tx_mp_d, tx_ack2_d, tx_tog_d, tx_code_d};
    end
  end

  always_comb begin
    test_d = test_q;
    man_en_d = man_en_q;
    man_val_d = man_val_q;
    port_d = port_q;
    fd_d = fd_q;
    hd_d = hd_q;
    xo_wr_d = xo_wr_q;
    xo_act_d = xo_act_q;
    man_en_out_d = MANUAL_ROLE_EN;
    role_out_d = ROLE_MASTER_WANTED;
    fd_out_d = ADV_FULL_DUPLEX;
    hd_out_d = ADV_HALF_DUPLEX;
    if (swrst_q) begin
      // Role and advertisement bits survive a soft reset; test mode does not
      test_d = TM_NORMAL;
      xo_act_d = xo_wr_q;
    end else if (acc_wr && wr_hit(PADDR, `IDX_ROLE)) begin
      test_d = test_mode_t'(PWDATA[`ROLE_TEST_MSB:`ROLE_TEST_LSB]);
      man_en_d = PWDATA[`ROLE_MEN_BIT];
      man_val_d = PWDATA[`ROLE_MVAL_BIT];
      port_d = PWDATA[`ROLE_PORT_BIT];
      fd_d = PWDATA[`ROLE_FD_BIT];
      hd_d = PWDATA[`ROLE_HD_BIT];
    end
    // The unused code is refused so the wiring field never holds it
    if (acc_wr && wr_hit(PADDR, `IDX_XOVER) && PWDATA[`XO_MSB:`XO_LSB] != XO_UNUSED) begin
      xo_wr_d = xover_t'(PWDATA[`XO_MSB:`XO_LSB]);
    end
    if (restart_q) begin
      man_en_out_d = man_en_q;
      role_out_d = man_en_q ? man_val_q : port_q;
      fd_out_d = fd_q;
      hd_out_d = hd_q;
    end
    // Test patterns on an auto-crossing link would confuse the partner
    case (test_q)
      TM_WAVEFORM, TM_JITTER_MASTER, TM_JITTER_SLAVE:
        test_out_d = (xo_act_q != XO_AUTO) ? test_q : TM_NORMAL;
      default: test_out_d = TM_NORMAL;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      test_q <= TM_NORMAL;
      man_en_q <= `ROLE_MEN_RST;
      man_val_q <= `ROLE_MVAL_RST;
      port_q <= `ROLE_PORT_RST;
      fd_q <= `ROLE_FD_RST;
      hd_q <= `ROLE_HD_RST;
      xo_wr_q <= XO_AUTO;
      xo_act_q <= XO_AUTO;
      MANUAL_ROLE_EN <= `ROLE_MEN_RST;
      ROLE_MASTER_WANTED <= `ROLE_PORT_RST;
      ADV_FULL_DUPLEX <= `ROLE_FD_RST;
      ADV_HALF_DUPLEX <= `ROLE_HD_RST;
      TX_TEST_MODE <= TM_NORMAL;
    end else begin
      test_q <= test_d;
      man_en_q <= man_en_d;
      man_val_q <= man_val_d;
      port_q <= port_d;
      fd_q <= fd_d;
      hd_q <= hd_d;
      xo_wr_q <= xo_wr_d;
      xo_act_q <= xo_act_d;
      MANUAL_ROLE_EN <= man_en_out_d;
      ROLE_MASTER_WANTED <= role_out_d;
      ADV_FULL_DUPLEX <= fd_out_d;
      ADV_HALF_DUPLEX <= hd_out_d;
      TX_TEST_MODE <= test_out_d;
    end
  end

  assign CROSSED_WIRING_MODE = xo_act_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_tx_next;
    acc_wr && wr_hit(PADDR, `IDX_TXP) && !swrst_q |=> tx_next_q == $past(PWDATA[15]);
  endproperty
  a_tx_next: assert property (p_tx_next) else $error("continuation flag not written");

  property p_tx_softreset;
    swrst_q |=> tx_mp_q && !tx_next_q && !tx_ack2_q && TX_PAGE_WORD[`PG_MP_BIT];
  endproperty
  a_tx_softreset: assert property (p_tx_softreset) else $error("page type not reloaded");

  property p_tx_ack2;
    acc_wr && wr_hit(PADDR, `IDX_TXP) && !swrst_q |=> tx_ack2_q == $past(PWDATA[12]);
  endproperty
  a_tx_ack2: assert property (p_tx_ack2) else $error("second acknowledge not written");

  property p_toggle;
    PAGE_TX_DONE && !swrst_q |=> tx_tog_q != $past(tx_tog_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert");

  property p_code_reset;
    swrst_q |=> tx_code_q == `TXP_CODE_RST && TX_PAGE_WORD[`PG_CODE_MSB:0] == `TXP_CODE_RST;
  endproperty
  a_code_reset: assert property (p_code_reset) else $error("code field reset wrong");

  property p_test_gate;
    TX_TEST_MODE != TM_NORMAL |-> $past(xo_act_q) != XO_AUTO;
  endproperty
  a_test_gate: assert property (p_test_gate) else $error("test mode under auto crossover");

  property p_test_softreset;
    swrst_q |=> test_q == TM_NORMAL ##1 TX_TEST_MODE == TM_NORMAL;
  endproperty
  a_test_softreset: assert property (p_test_softreset) else $error("test mode kept");

  property p_role_hold;
    !restart_q |=> $stable(ROLE_MASTER_WANTED) && $stable(ADV_FULL_DUPLEX)
      && $stable(ADV_HALF_DUPLEX) && $stable(MANUAL_ROLE_EN);
  endproperty
  a_role_hold: assert property (p_role_hold) else $error("role applied without restart");

  property p_role_resolve;
    restart_q |=> ROLE_MASTER_WANTED == ($past(man_en_q) ? $past(man_val_q) : $past(port_q));
  endproperty
  a_role_resolve: assert property (p_role_resolve) else $error("role resolved wrong");

  property p_role_keep;
    swrst_q |=> $stable(man_en_q) && $stable(man_val_q) && $stable(port_q) && $stable(fd_q)
      && $stable(hd_q);
  endproperty
  a_role_keep: assert property (p_role_keep) else $error("soft reset changed role bits");

  property p_na_zero;
    setup && !PWRITE && PADDR == {`IDX_ROLE, 2'h0} |=> PRDATA[7:0] == 8'h00
      && PRDATA[31:16] == 16'h0000;
  endproperty
  a_na_zero: assert property (p_na_zero) else $error("unused bits read nonzero");

  property p_xover_apply;
    swrst_q |=> CROSSED_WIRING_MODE == $past(xo_wr_q) && CROSSED_WIRING_MODE != XO_UNUSED;
  endproperty
  a_xover_apply: assert property (p_xover_apply) else $error("wiring mode not applied");

  c_tx_write: cover property (acc_wr && wr_hit(PADDR, `IDX_TXP));
  c_restart: cover property (restart_q ##1 ROLE_MASTER_WANTED != $past(ROLE_MASTER_WANTED));
  c_test_active: cover property (TX_TEST_MODE == TM_JITTER_SLAVE);

endmodule // phy_np_role_regs

`default_nettype wire

/* verilog/phy_regs_params.svh */
// Offsets, field positions and reset values of the next-page and role control registers.
// Assumes a 32-bit APB slave; the byte address of a register is four times its index.
`ifndef PHY_REGS_PARAMS_SVH
`define PHY_REGS_PARAMS_SVH

`define IDX_CTRL 6'h00
`define IDX_STAT 6'h06
`define IDX_TXP 6'h07
`define IDX_RXP 6'h08
`define IDX_ROLE 6'h09
`define IDX_XOVER 6'h10

`define CTRL_SWRST_BIT 15
`define CTRL_RESTART_BIT 9
`define STAT_PAGE_BIT 1

`define PG_NEXT_BIT 15
`define PG_MP_BIT 13
`define PG_ACK2_BIT 12
`define PG_TOG_BIT 11
`define PG_CODE_MSB 10

`define ROLE_TEST_MSB 15
`define ROLE_TEST_LSB 13
`define ROLE_MEN_BIT 12
`define ROLE_MVAL_BIT 11
`define ROLE_PORT_BIT 10
`define ROLE_FD_BIT 9
`define ROLE_HD_BIT 8
`define XO_MSB 6
`define XO_LSB 5

`define TXP_NEXT_RST 1'h0
`define TXP_MP_RST 1'h1
`define TXP_ACK2_RST 1'h0
`define TXP_TOG_RST 1'h0
`define TXP_CODE_RST 11'h001
`define RXP_RST 16'h0000
`define ROLE_MEN_RST 1'h0
`define ROLE_MVAL_RST 1'h1
`define ROLE_PORT_RST 1'h1
`define ROLE_FD_RST 1'h1
`define ROLE_HD_RST 1'h0

`endif

/* verilog/phy_regs_pkg.sv */
// Types shared by the register bank and its page capture unit.
// Assumes the constants header is included by the modules that need numbers.
`default_nettype none

package phy_regs_pkg;

  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0,
    TM_WAVEFORM = 3'h1,
    TM_JITTER_MASTER = 3'h2,
    TM_JITTER_SLAVE = 3'h3
  } test_mode_t;

  typedef enum logic [1:0] {
    XO_STRAIGHT = 2'h0,
    XO_CROSSED = 2'h1,
    XO_UNUSED = 2'h2,
    XO_AUTO = 2'h3
  } xover_t;

endpackage

`default_nettype wire

/* verilog/partner_page_capture.sv */
// Holds the partner's received next-page word and the latched page-received flag.
// Assumes page_stb is a one-cycle pulse from the negotiation engine.
`include "phy_regs_params.svh"
`default_nettype none

module partner_page_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_rst,
  // Page from the line side
  input wire logic page_stb,
  input wire logic [15:0] page_word,
  // Register side
  input wire logic clear_req,
  output logic [15:0] rx_word_q,
  output logic page_flag_q
);
  import phy_regs_pkg::*;

  logic [15:0] rx_word_d;
  logic page_flag_d;

  always_comb begin
    rx_word_d = rx_word_q;
    page_flag_d = page_flag_q;
    if (sw_rst) begin
      rx_word_d = `RXP_RST;
      page_flag_d = 1'h0;
    end else begin
      if (clear_req) begin
        page_flag_d = 1'h0;
      end
      // A new page in the clearing cycle still leaves the flag set
      if (page_stb) begin
        rx_word_d = page_word;
        page_flag_d = 1'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_word_q <= `RXP_RST;
      page_flag_q <= 1'h0;
    end else begin
      rx_word_q <= rx_word_d;
      page_flag_q <= page_flag_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rx_capture;
    page_stb && !sw_rst |=> rx_word_q == $past(page_word);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("received page not captured");

  property p_flag_set;
    page_stb && !sw_rst |=> page_flag_q ##1 (page_flag_q || $past(clear_req) || $past(sw_rst));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("page flag not latched");

  property p_flag_hold;
    page_flag_q && !clear_req && !sw_rst |=> page_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("page flag dropped unread");

  c_page_read: cover property (page_flag_q && clear_req);

endmodule // partner_page_capture

`default_nettype wire

/* tb/page_engine_model.sv */
// Behavioural model of the negotiation engine that faces the register bank.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none

module page_engine_model (
  // Clock
  input wire logic clk,
  // Toward the register bank
  output logic an_done,
  output logic page_stb,
  output logic [15:0] page_word,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    an_done = 1'b0;
    page_stb = 1'b0;
    page_word = 16'hFFFF;
    tx_done = 1'b0;
  end

  task automatic set_an(input logic v);
    @(posedge clk);
    an_done <= v;
  endtask

  // Word is only valid with the strobe; afterwards it shows the inverse
  task automatic send_page(input logic [15:0] w);
    @(posedge clk);
    page_stb <= 1'b1;
    page_word <= w;
    @(posedge clk);
    page_stb <= 1'b0;
    page_word <= ~w;
  endtask

  task automatic sent_page;
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
  endtask
endmodule // page_engine_model

`default_nettype wire

/* tb/phy_np_role_regs_bench.sv */
// Self-checking bench for the next-page and role control register bank.
// Assumes zero-wait APB answers and the page engine model on the far side.
`include "phy_regs_params.svh"
`default_nettype none

module phy_np_role_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_regs_pkg::*;

  localparam logic [7:0] A_CTRL = {`IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {`IDX_STAT, 2'b00};
  localparam logic [7:0] A_TXP = {`IDX_TXP, 2'b00};
  localparam logic [7:0] A_RXP = {`IDX_RXP, 2'b00};
  localparam logic [7:0] A_ROLE = {`IDX_ROLE, 2'b00};
  localparam logic [7:0] A_XO = {`IDX_XOVER, 2'b00};
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [7:0] ADR [3] = '{A_TXP, A_RXP, A_ROLE};
  localparam logic [15:0] RV [3] = '{16'h2001, 16'h0000, 16'h0E00};
  localparam logic [15:0] WV [3] = '{16'hB7FF, 16'h0000, 16'hFF00};
  // Role word and expected {manual enable, master wanted, full, half}
  localparam logic [19:0] RT [4] = '{20'h10008, 20'h1A00E, 20'h05005, 20'h0A002};

  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic an_complete, page_stb, page_tx_done, restart_an, soft_reset;
  logic [15:0] page_word, tx_page_word;
  logic manual_role_en, role_master_wanted, adv_fd, adv_hd;
  logic [3:0] role_o;
  logic [3:0] prev;
  test_mode_t tx_test_mode;
  xover_t wiring_mode;
  int failures;
  int comparisons;

  assign role_o = {manual_role_en, role_master_wanted, adv_fd, adv_hd};

  phy_np_role_regs DUT (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .AN_COMPLETE(an_complete), .PAGE_RX_STB(page_stb), .PAGE_RX_WORD(page_word),
    .PAGE_TX_DONE(page_tx_done), .TX_PAGE_WORD(tx_page_word), .RESTART_AN(restart_an),
    .SOFT_RESET(soft_reset), .MANUAL_ROLE_EN(manual_role_en),
    .ROLE_MASTER_WANTED(role_master_wanted), .ADV_FULL_DUPLEX(adv_fd),
    .ADV_HALF_DUPLEX(adv_hd), .TX_TEST_MODE(tx_test_mode), .CROSSED_WIRING_MODE(wiring_mode)
  );

  page_engine_model eng (
    .clk(ref_clk), .an_done(an_complete), .page_stb(page_stb), .page_word(page_word),
    .tx_done(page_tx_done)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held from setup until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (int n = 0; n < 50 && pready !== 1'b1; n++) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, addr, 32'h0);
    check(rd & m, e);
  endtask

  task automatic nxt;
    @(posedge ref_clk);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check({16'h0, tx_page_word}, 32'h2001);
    check({28'h0, role_o}, 32'h6);
    check({27'h0, tx_test_mode, wiring_mode}, 32'h3);
    for (int i = 0; i < 3; i++) begin
      rd_chk(ADR[i], ALL, {16'h0, RV[i]});
      apb(1'b1, ADR[i], ALL);
      rd_chk(ADR[i], ALL, {16'h0, WV[i]});
    end
    check({16'h0, tx_page_word}, 32'hB7FF);
    check({27'h0, tx_test_mode, wiring_mode}, 32'h3);
    apb(1'b1, A_TXP, 32'h0);
    rd_chk(A_TXP, ALL, 32'h0);
    eng.sent_page();
    rd_chk(A_TXP, ALL, 32'h0800);
    eng.sent_page();
    rd_chk(A_TXP, ALL, 32'h0);
    prev = 4'h6;
    // Host must restart negotiation before role changes apply
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_ROLE, {16'h0, RT[i][19:4]});
      nxt();
      check({28'h0, role_o}, {28'h0, prev});
      apb(1'b1, A_CTRL, 32'h0200);
      #1;
      check({31'h0, restart_an}, 32'h1);
      nxt();
      check({28'h0, role_o}, {28'h0, RT[i][3:0]});
      check({31'h0, restart_an}, 32'h0);
      prev = RT[i][3:0];
    end
    eng.send_page(16'hD5A5);
    rd_chk(A_STAT, 32'h2, 32'h0);
    rd_chk(A_RXP, ALL, 32'hD5A5);
    eng.set_an(1'b1);
    rd_chk(A_STAT, 32'h2, 32'h2);
    rd_chk(A_STAT, 32'h2, 32'h0);
    apb(1'b1, A_TXP, 32'h9005);
    eng.sent_page();
    #1;
    check({16'h0, tx_page_word}, 32'h9805);
    apb(1'b1, A_RXP, 32'h0);
    check({31'h0, err}, 32'h0);
    rd_chk(A_RXP, ALL, 32'hD5A5);
    apb(1'b1, A_ROLE, 32'h3B00);
    repeat (2) nxt();
    check({29'h0, tx_test_mode}, 32'h0);
    apb(1'b1, A_XO, 32'h0040);
    rd_chk(A_XO, ALL, 32'h0060);
    apb(1'b1, A_XO, 32'h0000);
    nxt();
    check({30'h0, wiring_mode}, 32'h3);
    apb(1'b1, A_CTRL, 32'h8000);
    #1;
    check({31'h0, soft_reset}, 32'h1);
    nxt();
    check({30'h0, wiring_mode}, 32'h0);
    check({28'h0, role_o}, {28'h0, prev});
    rd_chk(A_ROLE, ALL, 32'h1B00);
    rd_chk(A_TXP, ALL, 32'h2001);
    rd_chk(A_RXP, ALL, 32'h0);
    // Crossover now manual, so every defined test code reaches the line side
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, A_ROLE, {16'h0, m[2:0], 13'h1B00});
      repeat (2) nxt();
      check({29'h0, tx_test_mode}, {29'h0, (m < 4) ? m[2:0] : 3'h0});
    end
    apb(1'b1, A_XO, 32'h0020);
    apb(1'b1, A_CTRL, 32'h8000);
    nxt();
    check({30'h0, wiring_mode}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h1D, 32'h0);
    check({31'h0, err}, 32'h1);
    rd_chk(A_TXP, ALL, 32'h2001);
    test_done();
  end
endmodule // phy_np_role_regs_bench

`default_nettype wire
